/* rtl/dbs_pkg.sv */
// Constants, types and states for the burst memory port block.
// Assumes one configuration chosen at build time; widths fixed at the wide form.
package dbs_pkg;
	localparam int DBS_DW = 36;
	localparam int DBS_LANES = 4;
	localparam int DBS_LW = 9;
	localparam int DBS_AW = 18;
	localparam int DBS_DEPTH_LOG2 = 6;
	localparam int DBS_BEATS = 4;
	localparam logic [3:0] DBS_LAT_PLL = 4'h0005;
	localparam logic [3:0] DBS_LAT_DLL = 4'h0002;
	localparam logic [1:0] DBS_BEAT_RST = 2'h0;

	typedef struct packed {
		logic [DBS_DW-1:0] data;
		logic [DBS_LANES-1:0] mask_n;
	} dbs_beat_s;

	typedef enum logic [2:0] {
		DBS_W_IDLE = 3'b001,
		DBS_W_HALF = 3'b010,
		DBS_W_BUSY = 3'b100
	} dbs_wst_e;
endpackage : dbs_pkg

/* rtl/dbs_port.sv */
// Pin-level port logic of the burst memory: write, read, echo clocks.
// Assumes a 2x link clock whose even/odd half-cycles stand for K and K-bar edges.
`timescale 1ns/10ps
module dbs_port (
	input wire logic clock_i,
	input wire logic srst_i,
	input wire logic link_clk_i,
	input wire logic link_rst_i,
	input wire logic write_port_select_n_i,
	input wire logic read_port_select_n_i,
	input wire logic loop_disable_n_i,
	input wire logic [dbs_pkg::DBS_AW-1:0] addr_i,
	input wire dbs_pkg::dbs_beat_s wr_beat_i,
	output logic [dbs_pkg::DBS_DW-1:0] rd_data_o,
	output logic rd_data_oe_n_o,
	output logic read_data_valid_o,
	output logic echo_clk_o,
	output logic echo_clk_n_o,
	output logic loop_mode_o
);
	import dbs_pkg::*;

	localparam int DEPTH = 1 << DBS_DEPTH_LOG2;

	// Link domain state; each link clock rising edge is one input clock edge
	typedef struct packed {
		logic phase;
		dbs_wst_e wst;
		logic [1:0] wbeat;
		logic [DBS_DEPTH_LOG2-1:0] waddr;
		logic [DBS_DEPTH_LOG2-1:0] rq_addr;
		logic [15:0] rq_pipe;
		logic [15:0] rd_busy;
		logic [DBS_DW-1:0] q;
		logic q_oe_n;
		logic read_data_valid;
		logic cq;
		logic cq_n;
		logic rd_sel_d;
	} dbs_link_s;

	dbs_link_s l_r, l_nxt;
	logic [DBS_DW-1:0] mem [0:DEPTH*DBS_BEATS-1];
	logic [DEPTH*DBS_BEATS-1:0] dummy_unused;
	logic dis_s1_r, dis_s2_r;
	logic mode_s1_r;
	logic mode_r;
	logic [1:0] rd_beat;
	logic [3:0] lat;
	logic [DBS_DEPTH_LOG2+1:0] rd_idx;
	logic rd_hit;

	// Strap pin crosses into link clock; first flop feeds only the second
	always_ff @(posedge link_clk_i) begin
		dis_s1_r <= loop_disable_n_i;
		dis_s2_r <= dis_s1_r;
	end

	always_ff @(posedge clock_i) begin
		// Strap is a pin; two flops before anything reads it
		if (srst_i) begin
			mode_s1_r <= 1'b1;
			mode_r <= 1'b1;
		end else begin
			mode_s1_r <= loop_disable_n_i;
			mode_r <= mode_s1_r;
		end
	end
	assign loop_mode_o = mode_r;
	assign dummy_unused = '0;

	// Slot counted in half cycles; pipeline tap picks the latency mode
	assign lat = dis_s2_r ? DBS_LAT_PLL : DBS_LAT_DLL;
	// Beat index is the age of the request past the latency tap
	always_comb begin
		rd_hit = 1'b0;
		rd_beat = 2'h0;
		// Oldest pending beat wins; reads come at least one burst apart
		for (int i = 0; i < DBS_BEATS; i++) begin
			if (l_r.rd_busy[lat - 4'h1 + 4'(i)]) begin
				rd_hit = 1'b1;
				rd_beat = 2'(i);
			end
		end
	end
	assign rd_idx = {l_r.rq_addr, rd_beat};

	always_comb begin
		l_nxt = l_r;
		l_nxt.phase = ~l_r.phase;
		l_nxt.cq = ~l_r.cq;
		l_nxt.cq_n = ~l_r.cq_n;
		l_nxt.rq_pipe = {l_r.rq_pipe[14:0], 1'b0};
		l_nxt.rd_busy = {l_r.rd_busy[14:0], 1'b0};
		// Positive edge: commands and address sampled
		if (!l_r.phase) begin
			if (!read_port_select_n_i) begin
				l_nxt.rq_pipe[0] = 1'b1;
				l_nxt.rd_busy[0] = 1'b1;
				l_nxt.rq_addr = addr_i[DBS_DEPTH_LOG2-1:0];
			end
			if (l_r.wst == DBS_W_IDLE && !write_port_select_n_i) begin
				l_nxt.wst = DBS_W_BUSY;
				l_nxt.wbeat = DBS_BEAT_RST;
				l_nxt.waddr = addr_i[DBS_DEPTH_LOG2-1:0];
			end
		end
		if (l_r.wst == DBS_W_BUSY) begin
			l_nxt.wbeat = l_r.wbeat + 2'h1;
			if (l_r.wbeat == 2'h3) l_nxt.wst = DBS_W_IDLE;
		end
		// Four beats, one per edge; data valid tracks the beats exactly
		if (rd_hit) begin
			l_nxt.q = mem[rd_idx];
			l_nxt.q_oe_n = 1'b0;
			l_nxt.read_data_valid = 1'b1;
		end else begin
			l_nxt.read_data_valid = 1'b0;
			l_nxt.q_oe_n = 1'b1;
		end
	end

	// Array write; masked lanes keep old contents
	always_ff @(posedge link_clk_i) begin
		if (l_r.wst == DBS_W_BUSY) begin
			for (int b = 0; b < DBS_LANES; b++) begin
				if (!wr_beat_i.mask_n[b]) begin
					mem[{l_r.waddr, l_r.wbeat}][b*DBS_LW +: DBS_LW] <=
						wr_beat_i.data[b*DBS_LW +: DBS_LW];
				end
			end
		end
	end

	always_ff @(posedge link_clk_i) begin
		if (link_rst_i) begin
			l_r <= '{phase: 1'b0, wst: DBS_W_IDLE, wbeat: 2'h0, waddr: '0, rq_addr: '0,
				rq_pipe: '0, rd_busy: '0, q: '0, q_oe_n: 1'b1, read_data_valid: 1'b0, cq: 1'b0,
				cq_n: 1'b1, rd_sel_d: 1'b1};
		end else begin
			l_r <= l_nxt;
		end
	end

	assign rd_data_o = l_r.q;
	assign rd_data_oe_n_o = l_r.q_oe_n;
	assign read_data_valid_o = l_r.read_data_valid;
	assign echo_clk_o = l_r.cq;
	assign echo_clk_n_o = l_r.cq_n;
endmodule : dbs_port

/* verification/dbs_ctl.sv */
// Controller model facing dbs_port.
// Drives on falling link edges; K is the first link edge after reset.
`timescale 1ns/10ps
module dbs_ctl (
	input wire logic link_clk_i,
	input wire logic link_rst_i,
	output logic wr_n_o = 1'h1,
	output logic rd_n_o = 1'h1,
	output logic [17:0] addr_o = 18'h0,
	output logic [39:0] beat_o = 40'h0
);
	logic ph_r;
	always @(posedge link_clk_i) ph_r <= link_rst_i ? 1'h0 : !ph_r;
	task automatic cmd(input logic wr, input logic [17:0] a, input logic [39:0] b[4]);
		do @(negedge link_clk_i); while (ph_r);
		{wr_n_o, rd_n_o, addr_o} = {!wr, wr, a};
		for (int i = 0; i < 5; i++) begin
			@(negedge link_clk_i);
			{wr_n_o, rd_n_o, addr_o} = {2'h3, ~addr_o}; // Churns when unselected
			beat_o = wr && i < 4 ? b[i] : ~beat_o; // Churns when idle
		end
	endtask : cmd
endmodule : dbs_ctl

/* verification/dbs_port_properties.sv */
// Pin checker for dbs_port, link domain.
// First link edge after reset is taken as a K edge.
`timescale 1ns/10ps
module dbs_props (
	input wire logic clock_i, srst_i, link_clk_i, link_rst_i, loop_disable_n_i,
	input wire logic write_port_select_n_i, read_port_select_n_i, read_data_valid_o,
	input wire logic rd_data_oe_n_o, echo_clk_o, echo_clk_n_o
);
	logic ph_r;
	wire rd = !ph_r && !read_port_select_n_i, v = read_data_valid_o, lp = loop_disable_n_i;
	always_ff @(posedge link_clk_i) ph_r <= link_rst_i ? 1'h0 : !ph_r;
	default clocking @(posedge link_clk_i); endclocking
	default disable iff (link_rst_i);
	a_long_lat: assert property (rd && lp |-> ##[5:6] v) else $error("late");
	a_short_lat: assert property (rd && !lp |-> ##[2:3] v) else $error("late");
	a_four_beats: assert property ($rose(v) |-> v[*4]) else $error("burst");
	a_bus_on: assert property ($rose(v) |-> (!rd_data_oe_n_o)[*4]) else $error("off");
	a_valid_drive: assert property (v |-> !rd_data_oe_n_o) else $error("off");
	a_bus_free: assert property ($fell(v) |-> ##[0:2] rd_data_oe_n_o) else $error("held");
	a_echo_pair: assert property (echo_clk_n_o != echo_clk_o) else $error("echo");
	a_rst_idle: assert property (disable iff (1'h0) link_rst_i |=> !v) else $error("rst");
	c_long: cover property (rd && lp);
	c_short: cover property (rd && !lp);
	c_write: cover property (!ph_r && !write_port_select_n_i);
endmodule : dbs_props
bind dbs_port dbs_props i_dbs_props (.*);

/* verification/dbs_port_bench.sv */
// Bench for dbs_port: memory model and read-back compare.
// Checker arrives by bind; dbs_ctl drives the pins.
`timescale 1ns/10ps
module dbs_port_bench;
	logic clock_i = 1'h0, srst_i = 1'h1, link_clk_i = 1'h0, link_rst_i = 1'h1;
	logic loop_disable_n_i = 1'h1, write_port_select_n_i, read_port_select_n_i;
	logic rd_data_oe_n_o, read_data_valid_o, echo_clk_o, echo_clk_n_o, loop_mode_o;
	logic [5:0] a;
	logic [17:0] addr_i;
	logic [35:0] rd_data_o, mem[64][4], q[$];
	dbs_pkg::dbs_beat_s wr_beat_i, b[4];
	int seed = 96755, failures = 0, n_compared = 0;
	always #2 clock_i = !clock_i;
	initial #1.3 forever #15 link_clk_i = !link_clk_i;
	always @(negedge link_clk_i) if (read_data_valid_o === 1'h1) q.push_back(rd_data_o);
	dbs_port i_dbs_port (.*);
	dbs_ctl i_dbs_ctl (.link_clk_i, .link_rst_i, .wr_n_o(write_port_select_n_i),
		.rd_n_o(read_port_select_n_i), .addr_o(addr_i), .beat_o(wr_beat_i));
	task automatic check(input logic [35:0] s, e);
		n_compared++;
		if (s !== e) failures++;
		if (s !== e) $display("wrong value at %0t: %h", $time, s);
	endtask : check
	task automatic summarize;
		$display("%0d checks, %0d bad", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : summarize
	initial begin
		#100000 failures++; // Tests need about 6.4 us
		summarize();
	end
	initial begin
		repeat (5) @(negedge link_clk_i);
		{srst_i, link_rst_i} = 2'h0;
		for (int t = 0; t < 8; t++) begin
			a = 6'($random(seed));
			for (int w = 0; w < 2; w++) begin
				foreach (b[i]) b[i] = 40'({$random(seed), $random(seed)}) & {{36{1'h1}}, {4{w[0]}}};
				for (int i = 0; i < 16; i++) if (!b[i/4].mask_n[i%4])
					mem[a][i/4][i%4*9+:9] = b[i/4].data[i%4*9+:9];
				i_dbs_ctl.cmd(1'h1, {12'($random(seed)), a}, b);
			end
			loop_disable_n_i = !t[0];
			q.delete();
			i_dbs_ctl.cmd(1'h0, {12'($random(seed)), a}, b);
			repeat (8) @(negedge link_clk_i);
			check(36'(q.size()), 36'h4);
			check(36'(loop_mode_o), 36'(loop_disable_n_i));
			for (int i = 0; i < 4; i++) check(q[i], mem[a][i]);
			$display("test %0d done", t);
		end
		summarize();
	end
endmodule : dbs_port_bench
